// *** rtl/lpw_cfg.svh ***
// constants for the lcd prescale and waveform control register
// Function
// R1 - waveform bit picks type-B or type-A phasing
// R2 - software keeps bias bit zero in static
// R3 - mux 01/10: bias bit selects half/third
// R4 - mux 11 forces one-third bias
// R5 - status bit shows driver running state
// R6 - status bit shows pixel data write permission
// R7 - lcd clock divided by prescale plus one
// R8 - status bits read-only, other fields read/write
`ifndef LPW_CFG_SVH
`define LPW_CFG_SVH

`define LPW_ADDR_W        8
`define LPW_DATA_W        8
`define LPW_REG_OFF       8'h00

`define LPW_WFT_BIT       7
`define LPW_BIAS_BIT      6
`define LPW_ACTIVE_BIT    5
`define LPW_WA_BIT        4
`define LPW_PS_MSB        3
`define LPW_PS_LSB        0
`define LPW_PS_W          4

`define LPW_WFT_RST       1'b0
`define LPW_BIAS_RST      1'b0
`define LPW_PS_RST        4'h0

`define LPW_MUX_STATIC    2'h0
`define LPW_MUX_QUAD      2'h3

`endif

// *** rtl/lpw_pkg.sv ***
// types shared by the lcd prescale and waveform control block
package lpw_pkg;

  typedef enum logic [2:0] {
    LPW_ST_IDLE = 3'h1,
    LPW_ST_RUN  = 3'h2,
    LPW_ST_STOP = 3'h4
  } lpw_state_e;

  typedef enum logic [1:0] {
    LPW_BIAS_STATIC = 2'h0,
    LPW_BIAS_HALF   = 2'h1,
    LPW_BIAS_THIRD  = 2'h2
  } lpw_bias_e;

endpackage

// *** rtl/lpw_prescaler.sv ***
// lcd clock prescaler: one output pulse per (ratio + 1) input ticks
`timescale 1ns/10ps
`include "lpw_cfg.svh"

module lpw_prescaler (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  run,
  input  wire logic                  tick,
  input  wire logic [`LPW_PS_W-1:0]  ratio,
  output logic                       pulse
);
  import lpw_pkg::*;

  logic [`LPW_PS_W-1:0] cnt;
  logic [`LPW_PS_W-1:0] next_cnt;
  logic                 next_pulse;

  // >= rather than == so a ratio lowered mid-count does not wrap through 16
  always_comb begin
    next_cnt   = cnt;
    next_pulse = 1'b0;
    if (!run) begin
      next_cnt = '0;
    end else if (tick) begin
      if (cnt >= ratio) begin // [R7]
        next_cnt   = '0;
        next_pulse = 1'b1;
      end else begin
        next_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt   <= '0;
      pulse <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      pulse <= next_pulse;
    end
  end

  div_last_a: assert property (@(posedge clk) disable iff (reset) // [R7]
    run && tick && (cnt == ratio) |=> pulse)
    else $error("prescaler missed its terminal tick");

  div_mid_a: assert property (@(posedge clk) disable iff (reset) // [R7]
    run && tick && (cnt < ratio) |=> !pulse ##0 (cnt == $past(cnt) + 4'h1))
    else $error("prescaler pulsed before ratio plus one ticks");

endmodule

// *** rtl/lpw_top.sv ***
// lcd prescale and waveform control register with frame sequencing
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "lpw_cfg.svh"

module lpw_top (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic [`LPW_ADDR_W-1:0]  addr,
  input  wire logic [`LPW_DATA_W-1:0]  wdata,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic [`LPW_DATA_W-1:0]       rdata,
  input  wire logic                    lcd_enable,
  input  wire logic                    lcd_clk_tick,
  input  wire logic [1:0]              multiplex_sel,
  output logic                         waveform_phase,
  output logic [1:0]                   common_index,
  output logic                         frame_boundary,
  output lpw_pkg::lpw_bias_e           bias_level,
  output logic                         driver_active_flag,
  output logic                         pixel_write_allowed_flag
);
  import lpw_pkg::*;

  function automatic logic reg_hit(input logic [`LPW_ADDR_W-1:0] a);
    reg_hit = (a == `LPW_REG_OFF);
  endfunction

  // mux 11 ignores the bias bit so a stray 1 cannot select half bias
  function automatic lpw_bias_e bias_decode(input logic [1:0] mux, input logic sel);
    if (mux == `LPW_MUX_STATIC) begin
      bias_decode = LPW_BIAS_STATIC;
    end else if (mux == `LPW_MUX_QUAD) begin
      bias_decode = LPW_BIAS_THIRD; // [R4]
    end else if (sel) begin
      bias_decode = LPW_BIAS_HALF; // [R3]
    end else begin
      bias_decode = LPW_BIAS_THIRD; // [R3]
    end
  endfunction

  // software fields
  logic                 waveform_type_sel;
  logic                 bias_mode_sel;
  logic [`LPW_PS_W-1:0] clock_prescale_sel;
  logic                 next_waveform_type_sel;
  logic                 next_bias_mode_sel;
  logic [`LPW_PS_W-1:0] next_clock_prescale_sel;
  logic [`LPW_DATA_W-1:0] next_rdata;

  // frame sequencing
  lpw_state_e state;
  lpw_state_e next_state;
  logic       half;
  logic       next_half;
  logic [1:0] next_common_index;
  logic       next_waveform_phase;
  logic       next_frame_boundary;
  lpw_bias_e  next_bias_level;
  logic       next_driver_active_flag;
  logic       next_pixel_write_allowed_flag;
  logic       frame_end;
  logic       presc_pulse;

  lpw_prescaler u_prescaler (
    .clk   (clk),
    .reset (reset),
    .run   (driver_active_flag),
    .tick  (lcd_clk_tick),
    .ratio (clock_prescale_sel),
    .pulse (presc_pulse)
  );

  // register write: status bits 5:4 have no storage, so writes to them vanish
  always_comb begin
    next_waveform_type_sel  = waveform_type_sel;
    next_bias_mode_sel      = bias_mode_sel;
    next_clock_prescale_sel = clock_prescale_sel;
    if (wr_en && reg_hit(addr)) begin // [R8]
      next_waveform_type_sel  = wdata[`LPW_WFT_BIT];
      next_bias_mode_sel      = wdata[`LPW_BIAS_BIT];
      next_clock_prescale_sel = wdata[`LPW_PS_MSB:`LPW_PS_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      waveform_type_sel  <= `LPW_WFT_RST;
      bias_mode_sel      <= `LPW_BIAS_RST;
      clock_prescale_sel <= `LPW_PS_RST;
    end else begin
      waveform_type_sel  <= next_waveform_type_sel;
      bias_mode_sel      <= next_bias_mode_sel;
      clock_prescale_sel <= next_clock_prescale_sel;
    end
  end

  // register read: data one cycle after the strobe, zero otherwise and for other addresses
  always_comb begin
    next_rdata = '0;
    if (rd_en && reg_hit(addr)) begin
      next_rdata[`LPW_WFT_BIT]              = waveform_type_sel;
      next_rdata[`LPW_BIAS_BIT]             = bias_mode_sel;
      next_rdata[`LPW_ACTIVE_BIT]           = driver_active_flag; // [R5]
      next_rdata[`LPW_WA_BIT]               = pixel_write_allowed_flag; // [R6]
      next_rdata[`LPW_PS_MSB:`LPW_PS_LSB]   = clock_prescale_sel;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // each common period is two prescaled ticks; the last common index equals multiplex_sel.
  // a disable finishes the current frame so the panel never sees a net dc offset.
  always_comb begin
    next_state        = state;
    next_half         = half;
    next_common_index = common_index;
    frame_end         = 1'b0;
    case (state)
      LPW_ST_IDLE: begin
        next_half         = 1'b0;
        next_common_index = 2'h0;
        if (lcd_enable) begin
          next_state = LPW_ST_RUN;
        end
      end
      LPW_ST_RUN, LPW_ST_STOP: begin
        if (presc_pulse) begin
          if (!half) begin
            next_half = 1'b1;
          end else begin
            next_half = 1'b0;
            if (common_index >= multiplex_sel) begin
              next_common_index = 2'h0;
              frame_end         = 1'b1;
            end else begin
              next_common_index = common_index + 2'h1;
            end
          end
        end
        if (state == LPW_ST_RUN && !lcd_enable) begin
          next_state = LPW_ST_STOP;
        end else if (state == LPW_ST_STOP && frame_end) begin
          next_state = LPW_ST_IDLE;
        end
      end
      default: begin
        next_state = LPW_ST_IDLE;
      end
    endcase
  end

  always_comb begin
    if (waveform_type_sel) begin
      next_waveform_phase = frame_end ? ~waveform_phase : waveform_phase; // [R1]
    end else begin
      next_waveform_phase = next_half; // [R1]
    end
    next_frame_boundary           = frame_end;
    next_bias_level               = bias_decode(multiplex_sel, bias_mode_sel);
    next_driver_active_flag       = (next_state != LPW_ST_IDLE); // [R5]
    // pixel data are sampled in the closing half period of a frame
    next_pixel_write_allowed_flag = (next_state == LPW_ST_IDLE) ||
                                    !(next_half && next_common_index == multiplex_sel); // [R6]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state                    <= LPW_ST_IDLE;
      half                     <= 1'b0;
      common_index             <= 2'h0;
      waveform_phase           <= 1'b0;
      frame_boundary           <= 1'b0;
      bias_level               <= LPW_BIAS_STATIC;
      driver_active_flag       <= 1'b0;
      pixel_write_allowed_flag <= 1'b1;
    end else begin
      state                    <= next_state;
      half                     <= next_half;
      common_index             <= next_common_index;
      waveform_phase           <= next_waveform_phase;
      frame_boundary           <= next_frame_boundary;
      bias_level               <= next_bias_level;
      driver_active_flag       <= next_driver_active_flag;
      pixel_write_allowed_flag <= next_pixel_write_allowed_flag;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wft_store_a: assert property ( // [R1]
    wr_en && reg_hit(addr) |=> waveform_type_sel == $past(wdata[`LPW_WFT_BIT]))
    else $error("waveform type bit not stored");

  phase_b_a: assert property ( // [R1]
    waveform_type_sel && $past(waveform_type_sel) && $changed(waveform_phase) |-> frame_boundary)
    else $error("type-B phase moved off a frame boundary");

  phase_a_a: assert property ( // [R1]
    !waveform_type_sel && !$past(waveform_type_sel) && driver_active_flag && presc_pulse |=>
      waveform_phase != $past(waveform_phase))
    else $error("type-A phase did not change within the common period");

  bias_half_a: assert property ( // [R3]
    (multiplex_sel == 2'h1 || multiplex_sel == 2'h2) && bias_mode_sel |=> bias_level == LPW_BIAS_HALF)
    else $error("half bias not applied");

  bias_quad_a: assert property ( // [R4]
    multiplex_sel == `LPW_MUX_QUAD |=> bias_level == LPW_BIAS_THIRD)
    else $error("four-common mode left one-third bias");

  active_rd_a: assert property ( // [R5]
    rd_en && reg_hit(addr) |=> rdata[`LPW_ACTIVE_BIT] == $past(driver_active_flag))
    else $error("driver active bit misreported");

  active_on_a: assert property ( // [R5]
    !driver_active_flag && lcd_enable |=> driver_active_flag)
    else $error("driver did not start on enable");

  wa_rd_a: assert property ( // [R6]
    rd_en && reg_hit(addr) |=> rdata[`LPW_WA_BIT] == $past(pixel_write_allowed_flag))
    else $error("write allow bit misreported");

  wa_idle_a: assert property ( // [R6]
    !driver_active_flag |-> pixel_write_allowed_flag)
    else $error("writes blocked while driver idle");

  ro_bits_a: assert property ( // [R8]
    !driver_active_flag && !lcd_enable && wr_en && reg_hit(addr) |=> !driver_active_flag)
    else $error("software write changed the active status bit");

  fields_store_a: assert property ( // [R8]
    wr_en && reg_hit(addr) |=> bias_mode_sel == $past(wdata[`LPW_BIAS_BIT]) &&
      clock_prescale_sel == $past(wdata[`LPW_PS_MSB:`LPW_PS_LSB]))
    else $error("bias or prescale field not stored");

  hold_cfg_a: assert property ( // [R8]
    !(wr_en && reg_hit(addr)) |=> $stable(waveform_type_sel) && $stable(bias_mode_sel) &&
      $stable(clock_prescale_sel))
    else $error("control fields changed without a write");

  rd_fields_a: assert property ( // [R8]
    rd_en && reg_hit(addr) |=> rdata[`LPW_WFT_BIT] == $past(waveform_type_sel) &&
      rdata[`LPW_BIAS_BIT] == $past(bias_mode_sel) && rdata[`LPW_PS_MSB:`LPW_PS_LSB] == $past(clock_prescale_sel))
    else $error("control fields misreported");

  rd_map_a: assert property ( // [R8]
    rd_en && !reg_hit(addr) |=> rdata == '0)
    else $error("unmapped address returned data");

  bias_static_a: assert property ( // [R2]
    multiplex_sel == `LPW_MUX_STATIC |=> bias_level == LPW_BIAS_STATIC)
    else $error("static mode left static bias");

  bias_third_a: assert property ( // [R3]
    (multiplex_sel == 2'h1 || multiplex_sel == 2'h2) && !bias_mode_sel |=> bias_level == LPW_BIAS_THIRD)
    else $error("one-third bias not applied");

  phase_b_edge_a: assert property ( // [R1]
    $past(waveform_type_sel) && frame_boundary |-> $changed(waveform_phase))
    else $error("type-B phase held across a frame boundary");

  type_a_rest_a: assert property ( // [R1]
    !$past(waveform_type_sel) && frame_boundary |-> !waveform_phase)
    else $error("type-A frame did not close on phase zero");

  fb_pulse_a: assert property ( // [R1]
    frame_boundary |=> !frame_boundary)
    else $error("frame boundary longer than one cycle");

  idle_rest_a: assert property ( // [R5]
    !driver_active_flag |-> common_index == 2'h0 && !half)
    else $error("sequencer not at rest while inactive");

  active_drop_a: assert property ( // [R5]
    $fell(driver_active_flag) |-> frame_boundary)
    else $error("driver stopped in mid-frame");

  active_hold_a: assert property ( // [R5]
    driver_active_flag && !frame_end |=> driver_active_flag)
    else $error("driver stopped without a frame end");

  presc_run_a: assert property ( // [R7]
    presc_pulse |-> $past(driver_active_flag))
    else $error("prescaler pulsed while the driver was idle");

  wa_close_a: assert property ( // [R6]
    driver_active_flag && half && common_index == multiplex_sel && $stable(multiplex_sel) |->
      !pixel_write_allowed_flag)
    else $error("writes allowed in the closing half period");

  wa_open_a: assert property ( // [R6]
    driver_active_flag && !half |-> pixel_write_allowed_flag)
    else $error("writes blocked outside the closing half period");

  frame_type_b_c: cover property (waveform_type_sel && frame_boundary);
  quad_frame_c:   cover property (multiplex_sel == `LPW_MUX_QUAD && frame_boundary);
  stop_idle_c:    cover property (state == LPW_ST_STOP ##1 state == LPW_ST_IDLE);
  wa_low_c:       cover property (driver_active_flag && !pixel_write_allowed_flag);
  type_a_frame_c: cover property (!waveform_type_sel && frame_boundary);

endmodule

// *** verification/lpw_top_test.sv ***
// self-checking bench for the lcd prescale and waveform control register
`timescale 1ns/10ps
`include "lpw_cfg.svh"

module lpw_top_test;
  import lpw_pkg::*;
  logic       clk;
  logic       reset;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rdata;
  logic       lcd_enable;
  logic       lcd_clk_tick;
  logic [1:0] multiplex_sel;
  logic       waveform_phase;
  logic [1:0] common_index;
  logic       frame_boundary;
  lpw_bias_e  bias_level;
  logic       driver_active_flag;
  logic       pixel_write_allowed_flag;
  int         n_mismatch;
  int         cmp_count;
  int         period;
  int         toggles;
  int         wa_low;
  int         n;
  logic [7:0] rd_val;
  logic [1:0] top_com;
  // write value, idle read-back (status: inactive, writes allowed)
  logic [7:0] reg_rows [5][2] = '{'{8'hC5, 8'hD5}, '{8'h3A, 8'h1A}, '{8'hFF, 8'hDF},
                                  '{8'h30, 8'h10}, '{8'h00, 8'h10}};
  // mux, bias bit, expected bias level; only combinations software may set
  logic [7:0] bias_rows [6][3] = '{'{0, 0, 0}, '{1, 0, 2}, '{1, 1, 1}, '{2, 0, 2}, '{2, 1, 1}, '{3, 0, 2}};
  // waveform type, mux, prescale
  logic [7:0] frame_rows [6][3] = '{'{0, 1, 0}, '{0, 1, 3}, '{0, 1, 15}, '{0, 0, 0}, '{1, 3, 1}, '{0, 2, 2}};

  lpw_top u_dut (.clk, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata, .lcd_enable, .lcd_clk_tick,
                 .multiplex_sel, .waveform_phase, .common_index, .frame_boundary, .bias_level,
                 .driver_active_flag, .pixel_write_allowed_flag);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rd_val = rdata;
  endtask

  // one full frame, boundary to boundary, so a periodic count is exact
  task automatic measure;
    logic prev;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk);
        #1 n++;
      end while (frame_boundary !== 1'b1 && n < 2000);
    end
    prev = waveform_phase;
    period = 0;
    toggles = 0;
    wa_low = 0;
    top_com = 2'h0;
    do begin
      @(posedge clk);
      #1 period++;
      toggles += int'(waveform_phase !== prev);
      prev = waveform_phase;
      wa_low += int'(pixel_write_allowed_flag === 1'b0);
      if (common_index > top_com) begin
        top_com = common_index;
      end
    end while (frame_boundary !== 1'b1 && period < 2000);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {reset, addr, wdata, wr_en, rd_en, lcd_enable, lcd_clk_tick, multiplex_sel} = {1'b1, 22'h0};
    n_mismatch = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    #1 chk({driver_active_flag, pixel_write_allowed_flag, frame_boundary, rdata}, 11'h200);
    chk(bias_level, LPW_BIAS_STATIC);
    rd(`LPW_REG_OFF);
    chk(rd_val & 8'hEF, 8'h00);
    $display("test reset done");
    multiplex_sel <= 2'h1;
    foreach (reg_rows[i]) begin
      wr(`LPW_REG_OFF, reg_rows[i][0]);
      rd(`LPW_REG_OFF);
      chk(rd_val, reg_rows[i][1]);
    end
    $display("test register table done");
    wr(8'h01, 8'hFF);
    rd(8'h01);
    chk(rd_val, 8'h00);
    rd(`LPW_REG_OFF);
    chk(rd_val, 8'h10);
    $display("test unmapped address done");
    foreach (bias_rows[i]) begin
      wr(`LPW_REG_OFF, {1'b0, bias_rows[i][1][0], 6'h0});
      multiplex_sel <= bias_rows[i][0][1:0];
      repeat (3) @(posedge clk);
      #1 chk(bias_level, bias_rows[i][2]);
    end
    $display("test bias modes done");
    foreach (frame_rows[i]) begin
      wr(`LPW_REG_OFF, {frame_rows[i][0][0], 3'b000, frame_rows[i][2][3:0]});
      multiplex_sel <= frame_rows[i][1][1:0];
      lcd_enable <= 1'b1;
      lcd_clk_tick <= 1'b1;
      measure();
      chk(period, 2 * (frame_rows[i][1] + 1) * (frame_rows[i][2] + 1));
      chk(toggles, frame_rows[i][0] ? 1 : 2 * (frame_rows[i][1] + 1));
      chk(wa_low > 0 && wa_low < period, 1);
      chk(top_com, frame_rows[i][1]);
      rd(`LPW_REG_OFF);
      chk(rd_val & 8'hEF, {frame_rows[i][0][0], 3'b010, frame_rows[i][2][3:0]});
      @(posedge clk);
      lcd_enable <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        #1 n++;
      end while (driver_active_flag !== 1'b0 && n < 300);
      chk(n <= period + 4, 1);
      @(posedge clk);
      #1 chk({driver_active_flag, pixel_write_allowed_flag}, 2'b01);
      $display("test frame row %0d done", i);
    end
    // a reset in mid-frame must drop the driver at once
    lcd_enable <= 1'b1;
    repeat (9) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    lcd_enable <= 1'b0;
    #1 chk({driver_active_flag, pixel_write_allowed_flag, frame_boundary}, 3'b010);
    rd(`LPW_REG_OFF);
    chk(rd_val & 8'hEF, 8'h00);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
